// [shared/acp_cfg.svh]
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// register addresses on the cpu memory map
`define ACP_ADDR_RESULT_UPPER 16'hff07
`define ACP_ADDR_CHANNEL_SEL 16'hff8e
`define ACP_ADDR_PIN_CONFIG 16'hff8f
`define ACP_ADDR_PORT2_DIR 16'hff22

// reset values
`define ACP_RST_RESULT_UPPER 8'h00
`define ACP_RST_RESULT_WIDE 10'h000
`define ACP_RST_CHANNEL_SEL 8'h00
`define ACP_RST_PIN_CONFIG 8'h08
`define ACP_RST_PORT2_DIR 8'hff

// field positions and widths
`define ACP_RES_W 10
`define ACP_RES_UPPER_LSB 2
`define ACP_CHAN_CODE_W 3
`define ACP_CFG_CODE_W 3
`define ACP_CFG_STORE_MASK 8'h0f
`define ACP_NUM_PINS 6
`define ACP_DIR_FIXED_ONES 8'hc0
`define ACP_DIR_WRITE_MASK 8'h3f

// timing counts: step divider in clock cycles, sample time in divided steps
`define ACP_STEP_DIV 8
`define ACP_SAMPLE_STEPS 4

`endif

// [shared/acp_pkg.sv]
`include "acp_cfg.svh"

package acp_pkg;

  // one cpu memory access: byte or single-bit
  typedef struct packed {
    logic sel;
    logic wr;
    logic bit_op;
    logic [2:0] bit_idx;
    logic [15:0] addr;
    logic [7:0] wdata;
  } acp_bus_req_t;

  // drive of the six shared port-2 pins
  typedef struct packed {
    logic [`ACP_NUM_PINS-1:0] o;
    logic [`ACP_NUM_PINS-1:0] oe;
    logic [`ACP_NUM_PINS-1:0] analog_en;
    logic [`ACP_NUM_PINS-1:0] conv_sel;
  } acp_pin_out_t;

  // successive approximation sequencer
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_SAMPLE = 2'b01,
    ACP_CONVERT = 2'b10,
    ACP_DONE = 2'b11
  } acp_sar_state_t;

endpackage

// [src/acp_sar.sv]
`include "acp_cfg.svh"

module acp_sar
  import acp_pkg::*;
#(
  parameter int RES_W = `ACP_RES_W,
  parameter int SAMPLE_STEPS = `ACP_SAMPLE_STEPS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic step_en,
  input wire logic run,
  input wire logic restart,
  input wire logic comp_ge,
  // analog front end
  output logic [RES_W-1:0] tap_code,
  output logic sample_hold,
  // result
  output logic done,
  output logic [RES_W-1:0] result
);

  localparam int IDX_W = $clog2(RES_W);
  localparam int SMP_W = $clog2(SAMPLE_STEPS + 1);

  acp_sar_state_t state_reg;
  logic [RES_W-1:0] sar_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [SMP_W-1:0] smp_reg;

  generate
    if (RES_W < 2 || SAMPLE_STEPS < 1)
    begin : g_chk
      $error("acp_sar: unsupported parameters");
    end
  endgenerate

  // sequencer: sample, ten compare steps, hand over, repeat while running
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= ACP_IDLE;
      smp_reg <= '0;
      idx_reg <= '0;
      sar_reg <= '0;
    end
    else if (!run)
    begin
      state_reg <= ACP_IDLE;
    end
    else if (restart)
    begin
      state_reg <= ACP_SAMPLE;
      smp_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ACP_IDLE:
        begin
          state_reg <= ACP_SAMPLE;
          smp_reg <= '0;
        end
        ACP_SAMPLE:
        begin
          if (step_en)
          begin
            if (smp_reg == SMP_W'(SAMPLE_STEPS - 1))
            begin
              state_reg <= ACP_CONVERT;
              idx_reg <= IDX_W'(RES_W - 1);
              sar_reg <= RES_W'(1) << (RES_W - 1);
            end
            else
            begin
              smp_reg <= smp_reg + SMP_W'(1);
            end
          end
        end
        ACP_CONVERT:
        begin
          if (step_en)
          begin
            if (!comp_ge)
            begin
              sar_reg[idx_reg] <= 1'b0;
            end
            if (idx_reg == '0)
            begin
              state_reg <= ACP_DONE;
            end
            else
            begin
              sar_reg[idx_reg - IDX_W'(1)] <= 1'b1;
              idx_reg <= idx_reg - IDX_W'(1);
            end
          end
        end
        ACP_DONE:
        begin
          state_reg <= ACP_SAMPLE;
          smp_reg <= '0;
        end
        default:
        begin
          state_reg <= ACP_IDLE;
        end
      endcase
    end
  end

  // outputs toward tap selector and result latch
  assign tap_code = sar_reg;
  assign sample_hold = (state_reg == ACP_SAMPLE);
  assign done = (state_reg == ACP_DONE) && run && !restart;
  assign result = sar_reg;

  property p_sar_msb_first;
    @(posedge clk) disable iff (!rstn)
    (state_reg == ACP_SAMPLE) ##1 (state_reg == ACP_CONVERT) |-> sar_reg[RES_W-1] && (idx_reg == IDX_W'(RES_W - 1));
  endproperty
  a_sar_msb_first: assert property (p_sar_msb_first) else $error("conversion did not start at msb");

  property p_sar_stop;
    @(posedge clk) disable iff (!rstn)
    !run |=> (state_reg == ACP_IDLE) && !done;
  endproperty
  a_sar_stop: assert property (p_sar_stop) else $error("sequencer kept running after stop");

endmodule

// [src/acp_top.sv]
`include "acp_cfg.svh"

// Operation
// - short result register holds upper eight bits of ten-bit result
// - short result register is read-only and answers byte reads
// - mode, channel or config writes may spoil the short result
// - reading the short result register inserts one wait cycle
// - channel codes zero to five select inputs zero to five
// - channel register takes bit or byte writes, resets to zero
// - channel writes insert a wait cycle; avoid with clock halted
// - config register switches six pins analog or digital, resets 08
// - config writes insert a wait cycle; avoid with clock halted
// - segment selection drives segment output regardless of config
// - direction zero enables output buffer on digital pins; bits six, seven read one
// - analog input only while direction bit is one
// - direction register resets to all ones, bit or byte writes
// - analog input pin feeds converter only when channel selects it
// - short result mirrors upper byte of the wide result word
// - channel rewrite during conversion restarts on the new channel
// - a conversion end with run set and no channel write in that cycle stores result and raises completion request
module acp_top
  import acp_pkg::*;
#(
  parameter int NUM_PINS = `ACP_NUM_PINS,
  parameter int RES_W = `ACP_RES_W,
  parameter int STEP_DIV = `ACP_STEP_DIV,
  parameter int SAMPLE_STEPS = `ACP_SAMPLE_STEPS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // cpu memory access
  input acp_bus_req_t bus_req,
  output logic bus_wait,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // converter control
  input wire logic conversion_run_bit,
  output logic conversion_done_irq,
  output logic [RES_W-1:0] result_wide_word,
  // analog front end
  input wire logic comp_in,
  output logic [RES_W-1:0] tap_code,
  output logic sample_hold,
  // port-2 shared pins
  input wire logic [NUM_PINS-1:0] pin_i,
  input wire logic [NUM_PINS-1:0] port2_latch,
  input wire logic [NUM_PINS-1:0] segment_outputs,
  input wire logic [NUM_PINS-1:0] port2_function_select,
  output acp_pin_out_t port2_pins,
  output logic [NUM_PINS-1:0] dig_in
);

  generate
    if (NUM_PINS != `ACP_NUM_PINS || RES_W < 8 || STEP_DIV < 1)
    begin : g_chk
      $error("acp_top: unsupported parameters");
    end
  endgenerate

  localparam int DIV_W = $clog2(STEP_DIV + 1);

  logic [7:0] input_channel_select_reg;
  logic [7:0] analog_pin_config_reg;
  logic [7:0] port2_direction_reg;
  logic [7:0] result_upper_byte;
  logic wait_done_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic irq_reg;
  logic [RES_W-1:0] result_reg;
  logic [DIV_W-1:0] div_reg;
  logic step_en;
  logic comp_meta_reg;
  logic comp_sync_reg;
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic exec;
  logic exec_wr;
  logic restart;
  logic sar_done;
  logic [RES_W-1:0] sar_result;
  logic [NUM_PINS-1:0] analog_mask;
  logic [NUM_PINS-1:0] chan_onehot;

  // registers that stall the cpu for one cycle
  function automatic logic acp_needs_wait(input logic [15:0] addr);
    acp_needs_wait = (addr == `ACP_ADDR_RESULT_UPPER) || (addr == `ACP_ADDR_CHANNEL_SEL)
                     || (addr == `ACP_ADDR_PIN_CONFIG);
  endfunction

  // byte write or single-bit write onto an old value
  function automatic logic [7:0] acp_merge(input logic [7:0] old, input acp_bus_req_t r);
    logic [7:0] res;
    res = old;
    if (r.bit_op)
    begin
      res[r.bit_idx] = r.wdata[0];
    end
    else
    begin
      res = r.wdata;
    end
    acp_merge = res;
  endfunction

  // write decode used for each writable register
  function automatic logic acp_hit(input acp_bus_req_t r, input logic go, input logic [15:0] addr);
    acp_hit = go && r.wr && (r.addr == addr);
  endfunction

  // wait insertion: first cycle stalls, second cycle executes
  assign bus_wait = bus_req.sel && acp_needs_wait(bus_req.addr) && !wait_done_reg;
  assign exec = bus_req.sel && !bus_wait;
  assign exec_wr = exec && bus_req.wr;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wait_done_reg <= 1'b0;
    end
    else
    begin
      wait_done_reg <= bus_wait;
    end
  end

  // channel selection register, low code bits only
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      input_channel_select_reg <= `ACP_RST_CHANNEL_SEL;
    end
    else if (acp_hit(bus_req, exec, `ACP_ADDR_CHANNEL_SEL))
    begin
      input_channel_select_reg <= acp_merge(input_channel_select_reg, bus_req) & 8'h07;
    end
  end

  // pin configuration register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      analog_pin_config_reg <= `ACP_RST_PIN_CONFIG;
    end
    else if (acp_hit(bus_req, exec, `ACP_ADDR_PIN_CONFIG))
    begin
      analog_pin_config_reg <= acp_merge(analog_pin_config_reg, bus_req) & `ACP_CFG_STORE_MASK;
    end
  end

  // port-2 direction register, top bits fixed at one
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      port2_direction_reg <= `ACP_RST_PORT2_DIR;
    end
    else if (acp_hit(bus_req, exec, `ACP_ADDR_PORT2_DIR))
    begin
      port2_direction_reg <= (acp_merge(port2_direction_reg, bus_req) & `ACP_DIR_WRITE_MASK)
                             | `ACP_DIR_FIXED_ONES;
    end
  end

  // a channel write restarts the running conversion
  assign restart = acp_hit(bus_req, exec, `ACP_ADDR_CHANNEL_SEL);

  // read data path; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= exec && !bus_req.wr;
      if (exec && !bus_req.wr)
      begin
        case (bus_req.addr)
          `ACP_ADDR_RESULT_UPPER: rdata_reg <= result_upper_byte;
          `ACP_ADDR_CHANNEL_SEL: rdata_reg <= input_channel_select_reg;
          `ACP_ADDR_PIN_CONFIG: rdata_reg <= analog_pin_config_reg;
          `ACP_ADDR_PORT2_DIR: rdata_reg <= port2_direction_reg;
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign bus_rdata = rdata_reg;
  assign bus_rvalid = rvalid_reg;

  // divider giving the converter step enable
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_reg <= '0;
    end
    else if (div_reg == DIV_W'(STEP_DIV - 1))
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  assign step_en = (div_reg == DIV_W'(STEP_DIV - 1));

  // comparator and pin inputs cross from the analog side
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      comp_meta_reg <= comp_in;
      comp_sync_reg <= comp_meta_reg;
      pin_meta_reg <= pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  acp_sar #(
    .RES_W(RES_W),
    .SAMPLE_STEPS(SAMPLE_STEPS)
  ) u_sar (
    .clk(clk),
    .rstn(rstn),
    .step_en(step_en),
    .run(conversion_run_bit),
    .restart(restart),
    .comp_ge(comp_sync_reg),
    .tap_code(tap_code),
    .sample_hold(sample_hold),
    .done(sar_done),
    .result(sar_result)
  );

  // result latch and completion request at each conversion end not cut by a channel write or run clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      result_reg <= `ACP_RST_RESULT_WIDE;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= sar_done;
      if (sar_done)
      begin
        result_reg <= sar_result;
      end
    end
  end

  assign result_wide_word = result_reg;
  assign result_upper_byte = result_reg[RES_W-1 -: 8];
  assign conversion_done_irq = irq_reg;

  // config code k makes the top k pins digital; prohibited codes all digital
  always_comb
  begin
    analog_mask = '0;
    if (analog_pin_config_reg[`ACP_CFG_CODE_W-1:0] <= 3'd6)
    begin
      analog_mask = NUM_PINS'(6'h3f >> analog_pin_config_reg[`ACP_CFG_CODE_W-1:0]);
    end
  end

  // channel decode, codes six and seven select nothing
  generate
    for (genvar n = 0; n < NUM_PINS; n++)
    begin : g_pin
      assign chan_onehot[n] = (input_channel_select_reg[`ACP_CHAN_CODE_W-1:0] == 3'(n));
      assign port2_pins.o[n] = port2_function_select[n] ? segment_outputs[n] : port2_latch[n];
      assign port2_pins.oe[n] = port2_function_select[n]
                                || (!analog_mask[n] && !port2_direction_reg[n]);
      assign port2_pins.analog_en[n] = !port2_function_select[n] && analog_mask[n]
                                       && port2_direction_reg[n];
      assign port2_pins.conv_sel[n] = port2_pins.analog_en[n] && chan_onehot[n];
      assign dig_in[n] = pin_sync_reg[n] && !analog_mask[n];
    end
  endgenerate

  property p_wait_once;
    @(posedge clk) disable iff (!rstn)
    bus_wait |=> !bus_wait;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("wait lasted more than one cycle");

  sequence s_result_read;
    bus_req.sel && !bus_req.wr && (bus_req.addr == `ACP_ADDR_RESULT_UPPER);
  endsequence

  // first cycle of a short result read, stalled
  sequence s_result_stall;
    s_result_read ##0 bus_wait;
  endsequence

  property p_result_read;
    @(posedge clk) disable iff (!rstn)
    s_result_stall ##1 s_result_read |=> bus_rvalid && (bus_rdata == $past(result_reg[RES_W-1 -: 8]));
  endproperty
  a_result_read: assert property (p_result_read) else $error("short result read wrong");

  property p_result_ro;
    @(posedge clk) disable iff (!rstn)
    (exec_wr && (bus_req.addr == `ACP_ADDR_RESULT_UPPER) && !sar_done) |=> $stable(result_reg);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("short result changed by write");

  property p_chan_write;
    @(posedge clk) disable iff (!rstn)
    (exec_wr && (bus_req.addr == `ACP_ADDR_CHANNEL_SEL) && !bus_req.bit_op)
      |=> input_channel_select_reg == ($past(bus_req.wdata) & 8'h07);
  endproperty
  a_chan_write: assert property (p_chan_write) else $error("channel byte write not stored");

  property p_chan_wait;
    @(posedge clk) disable iff (!rstn)
    (bus_req.sel && bus_req.wr && (bus_req.addr == `ACP_ADDR_CHANNEL_SEL) && !wait_done_reg)
      |-> bus_wait ##1 $stable(input_channel_select_reg);
  endproperty
  a_chan_wait: assert property (p_chan_wait) else $error("channel write without wait");

  property p_cfg_wait;
    @(posedge clk) disable iff (!rstn)
    (bus_req.sel && bus_req.wr && (bus_req.addr == `ACP_ADDR_PIN_CONFIG) && !wait_done_reg) |-> bus_wait;
  endproperty
  a_cfg_wait: assert property (p_cfg_wait) else $error("config write without wait");

  property p_dir_top;
    @(posedge clk) disable iff (!rstn)
    port2_direction_reg[7:6] == 2'b11;
  endproperty
  a_dir_top: assert property (p_dir_top) else $error("direction top bits not one");

  property p_seg_prio;
    @(posedge clk) disable iff (!rstn)
    port2_function_select[0] |-> port2_pins.oe[0] && (port2_pins.o[0] == segment_outputs[0])
                                 && !port2_pins.analog_en[0];
  endproperty
  a_seg_prio: assert property (p_seg_prio) else $error("segment output lost priority");

  property p_analog_dir;
    @(posedge clk) disable iff (!rstn)
    (port2_pins.conv_sel != '0) |-> ((port2_pins.conv_sel & ~port2_direction_reg[NUM_PINS-1:0]) == '0)
                                    && $onehot(port2_pins.conv_sel);
  endproperty
  a_analog_dir: assert property (p_analog_dir) else $error("output-mode pin feeds converter");

  property p_done_irq;
    @(posedge clk) disable iff (!rstn)
    sar_done |=> conversion_done_irq && (result_reg == $past(sar_result)) ##1 !conversion_done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion not stored or flagged");

  property p_restart;
    @(posedge clk) disable iff (!rstn)
    (restart && conversion_run_bit) |=> sample_hold && !conversion_done_irq;
  endproperty
  a_restart: assert property (p_restart) else $error("channel write did not restart");

endmodule

// [dv/tb_top.sv]
`include "acp_cfg.svh"

module tb_top
  import acp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic rstn = 1'b0;
  acp_bus_req_t bus_req = '0;
  logic run = 1'b0;
  logic comp_in = 1'b0;
  logic [5:0] pin_i = 6'h2a;
  logic [5:0] latch = 6'h15;
  logic [5:0] seg = 6'h0b;
  logic [5:0] fsel = 6'h00;
  // observed outputs
  logic bus_wait;
  logic bus_rvalid;
  logic irq;
  logic sh;
  logic [7:0] bus_rdata;
  logic [9:0] res;
  logic [9:0] tap;
  acp_pin_out_t pins;
  logic [5:0] dig_in;
  int mismatches = 0;
  int checks_done = 0;

  // 25 mhz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // short counts keep each conversion near 35 cycles
  acp_top #(.STEP_DIV(3), .SAMPLE_STEPS(1)) i_dut (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_wait(bus_wait), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .conversion_run_bit(run), .conversion_done_irq(irq),
    .result_wide_word(res), .comp_in(comp_in), .tap_code(tap), .sample_hold(sh), .pin_i(pin_i),
    .port2_latch(latch), .segment_outputs(seg), .port2_function_select(fsel),
    .port2_pins(pins), .dig_in(dig_in));

  // verdict and end of run
  task automatic results();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // compare with case equality, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one cpu access; sel held through any wait cycle, read data taken with rvalid
  task automatic acc(input logic [15:0] a, input logic wr, input logic bo, input logic [2:0] bi,
                     input logic [7:0] wd, output logic [7:0] rd, output int nw);
    logic w;
    nw = 0;
    rd = 8'h00;
    @(posedge clk);
    bus_req <= '{sel: 1'b1, wr: wr, bit_op: bo, bit_idx: bi, addr: a, wdata: wd};
    do
    begin
      @(negedge clk);
      w = bus_wait;
      @(posedge clk);
      if (w === 1'b1)
        nw++;
    end
    while (w === 1'b1 && nw < 4);
    bus_req <= '0;
    if (!wr)
    begin
      @(negedge clk);
      chk(bus_rvalid, 1);
      rd = bus_rdata;
    end
  endtask

  // read and compare value and number of stall cycles
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input int expw);
    logic [7:0] d;
    int n;
    acc(a, 1'b0, 1'b0, 3'h0, 8'h00, d, n);
    chk(d, exp);
    chk(n, expw);
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] v);
    logic [7:0] d;
    int n;
    acc(a, 1'b1, 1'b0, 3'h0, v, d, n);
  endtask

  task automatic wrb(input logic [15:0] a, input logic [2:0] i, input logic v);
    logic [7:0] d;
    int n;
    acc(a, 1'b1, 1'b1, i, {7'h00, v}, d, n);
  endtask

  // wait for a completion pulse, at most lim cycles
  task automatic wait_irq(input int lim, output logic hit);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq !== 1'b1 && n < lim);
    hit = (irq === 1'b1);
  endtask

  // reset values, stall cycles, unmapped read
  task automatic t_reset();
    rd_chk(`ACP_ADDR_RESULT_UPPER, 8'h00, 1);
    rd_chk(`ACP_ADDR_CHANNEL_SEL, 8'h00, 1);
    rd_chk(`ACP_ADDR_PIN_CONFIG, 8'h08, 1);
    rd_chk(`ACP_ADDR_PORT2_DIR, 8'hff, 0);
    rd_chk(16'hff00, 8'h00, 0);
  endtask

  // every channel code routes its pin, bit and byte writes
  task automatic t_channel();
    logic [5:0] e;
    for (int c = 0; c < 8; c++)
    begin
      wr8(`ACP_ADDR_CHANNEL_SEL, 8'(c));
      @(negedge clk);
      e = (c < 6) ? (6'h01 << c) : 6'h00;
      chk(pins.conv_sel, e);
    end
    wr8(`ACP_ADDR_CHANNEL_SEL, 8'h05);
    rd_chk(`ACP_ADDR_CHANNEL_SEL, 8'h05, 1);
    wr8(`ACP_ADDR_CHANNEL_SEL, 8'h00);
    wrb(`ACP_ADDR_CHANNEL_SEL, 3'h2, 1'b1);
    rd_chk(`ACP_ADDR_CHANNEL_SEL, 8'h04, 1);
    chk(pins.conv_sel, 6'h10);
    wr8(`ACP_ADDR_CHANNEL_SEL, 8'h00);
  endtask

  // config codes switch pins between analog and digital
  task automatic t_config();
    logic [5:0] e;
    for (int k = 0; k < 8; k++)
    begin
      wr8(`ACP_ADDR_PIN_CONFIG, 8'(k));
      @(negedge clk);
      e = (k < 7) ? (6'h3f >> k) : 6'h00;
      chk(pins.analog_en, e);
    end
    repeat (3) @(negedge clk);
    chk(dig_in, 6'h2a);
    wr8(`ACP_ADDR_PIN_CONFIG, 8'hff);
    rd_chk(`ACP_ADDR_PIN_CONFIG, 8'h0f, 1);
    wr8(`ACP_ADDR_PIN_CONFIG, 8'h08);
    @(negedge clk);
    chk(dig_in, 6'h00);
  endtask

  // direction, analog gating by direction, segment priority
  task automatic t_direction();
    wr8(`ACP_ADDR_PIN_CONFIG, 8'h07);
    wr8(`ACP_ADDR_PORT2_DIR, 8'h00);
    rd_chk(`ACP_ADDR_PORT2_DIR, 8'hc0, 0);
    chk(pins.oe, 6'h3f);
    chk(pins.o, 6'h15);
    wrb(`ACP_ADDR_PORT2_DIR, 3'h0, 1'b1);
    rd_chk(`ACP_ADDR_PORT2_DIR, 8'hc1, 0);
    chk(pins.oe, 6'h3e);
    wr8(`ACP_ADDR_PIN_CONFIG, 8'h08);
    @(negedge clk);
    chk(pins.analog_en, 6'h01);
    @(posedge clk);
    fsel <= 6'h3f;
    @(negedge clk);
    chk(pins.oe, 6'h3f);
    chk(pins.o, 6'h0b);
    @(posedge clk);
    fsel <= 6'h00;
    wr8(`ACP_ADDR_PORT2_DIR, 8'hff);
  endtask

  // full-scale conversion, short result mirrors upper bits, write ignored
  task automatic t_convert();
    logic hit;
    @(posedge clk);
    comp_in <= 1'b1;
    run <= 1'b1;
    wait_irq(200, hit);
    chk(hit, 1);
    chk(res, 10'h3ff);
    chk(tap, 10'h3ff);
    rd_chk(`ACP_ADDR_RESULT_UPPER, 8'hff, 1);
    wr8(`ACP_ADDR_RESULT_UPPER, 8'h55);
    rd_chk(`ACP_ADDR_RESULT_UPPER, 8'hff, 1);
  endtask

  // channel write mid-conversion starts a fresh zero-scale conversion
  task automatic t_restart();
    logic hit;
    wait_irq(200, hit);
    rd_chk(`ACP_ADDR_RESULT_UPPER, 8'hff, 1);
    @(posedge clk);
    comp_in <= 1'b0;
    repeat (14) @(posedge clk);
    wr8(`ACP_ADDR_CHANNEL_SEL, 8'h01);
    @(negedge clk);
    chk(sh, 1);
    wait_irq(24, hit);
    chk(hit, 0);
    wait_irq(200, hit);
    chk(hit, 1);
    chk(res, 10'h000);
    chk(tap, 10'h000);
    rd_chk(`ACP_ADDR_RESULT_UPPER, 8'h00, 1);
    @(posedge clk);
    run <= 1'b0;
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_channel();
    t_config();
    t_direction();
    t_convert();
    t_restart();
    results();
  end

  // hang guard, far beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
